// *** card_flow_map.vh ***
// Constants for the card host flow-control block.
// Assumes inclusion by the design files only; holds definitions alone.
`ifndef CARD_FLOW_MAP_VH
`define CARD_FLOW_MAP_VH

// Interface modes, one-hot
`define MODE_MEM 3'b001
`define MODE_IO 3'b010
`define MODE_IDE 3'b100

// Reset initialization time in ns and its cycle count at 200 MHz
`define INIT_TIME_NS 100
`define CLK_PERIOD_NS 5
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Output reset values
`define WAIT_IDLE 1'b1
`define STROBE_RESET 1'b0
`define WP_RESET 1'b1

`endif

// *** card_host_flow.v ***
// Card-side pin logic for host flow control, mode strobes and status pins.
// Assumes host pins are asynchronous; internal requests come from clk logic.
`include "card_flow_map.vh"
`timescale 1ns/10ps

// How it works
// RULE1: Hold cycle-extension low to stall host cycle
// RULE2: Same pin acts as ready in IDE
// RULE3: Negate write-ready to pause Ultra DMA write
// RULE4: Card drives strobe; host latches both edges
// RULE5: Stop strobe edges to pause data-out
// RULE6: Memory mode write strobe hits task, config
// RULE7: I/O mode write strobe hits config only
// RULE8: IDE mode ignores write strobe input
// RULE9: Write-protect driven low after reset init
// RULE10: I/O mode pin flags wide port low
// RULE11: IDE word-cycle output low on word transfer
// RULE12: Primary sense grounded, secondary unconnected
// RULE13: Interface select latched at reset release; code samples it once, when init_cnt reaches 2
// RULE14: Wait outputs idle when no cycle
module card_host_flow #(
  parameter INIT_COUNT = `INIT_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire interface_select_n,
  input wire host_cycle_n,
  input wire write_strobe_n,
  input wire config_space,
  input wire core_busy,
  input wire port_wide,
  input wire word_expected,
  input wire udma_write_active,
  input wire udma_can_accept,
  input wire udma_read_active,
  input wire udma_word_send,
  output reg wait_ready,
  output reg udma_write_ready_n,
  output reg udma_read_strobe,
  output reg write_protect_pin,
  output reg port_is_wide_n,
  output reg port_is_wide_oe,
  output reg word_cycle_select_n,
  output reg voltage_sense_primary_n,
  output reg voltage_sense_primary_oe,
  output reg voltage_sense_secondary_oe,
  output reg task_write,
  output reg config_write,
  output reg [2:0] mode,
  output reg init_done
);
  // Synchronised host pins: select, cycle, write strobe
  wire [2:0] pins_s;
  // Previous write strobe level for falling-edge detect
  reg we_prev;
  // Reset initialization counter
  reg [15:0] init_cnt;
  // Mode captured once after reset
  reg mode_taken;
  // Strobe from the generator
  wire strobe_raw;
  // Next value of the mode register
  reg [2:0] next_mode;

  // Host pins idle high; select defaults high (memory mode)
  pin_sync #(
    .WIDTH(3),
    .INIT(3'b111)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .d({interface_select_n, host_cycle_n, write_strobe_n}),
    .q(pins_s)
  );

  // RULE4: card generates strobe
  udma_strobe_gen u_strobe (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .burst_active(udma_read_active),
    .word_send(udma_word_send),
    .strobe(strobe_raw)
  );

  // Decode the select level into a one-hot mode
  always @* begin
    // RULE13: high selects PC Card, low IDE
    if (pins_s[2]) begin
      next_mode = `MODE_MEM;
    end else begin
      next_mode = `MODE_IDE;
    end
  end

  // Mode and initialization sequence; select is caught after release, not in reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= `MODE_MEM;
      mode_taken <= 1'b0;
      init_cnt <= 16'h0000;
      init_done <= 1'b0;
    end else if (ce) begin
      // RULE13: sample select once after reset
      if (!mode_taken && init_cnt == 16'h0002) begin
        mode <= next_mode;
        mode_taken <= 1'b1;
      end
      if (!init_done) begin
        // Count out the initialization time
        if (init_cnt >= INIT_COUNT[15:0]) begin
          init_done <= 1'b1;
        end else begin
          init_cnt <= init_cnt + 16'h0001;
        end
      end
    end
  end

  // Write strobe steering by mode
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      we_prev <= 1'b1;
      task_write <= 1'b0;
      config_write <= 1'b0;
    end else if (ce) begin
      we_prev <= pins_s[0];
      task_write <= 1'b0;
      config_write <= 1'b0;
      if (init_done && we_prev && !pins_s[0] && !pins_s[1]) begin
        case (mode)
          `MODE_MEM: begin
            // RULE6: memory strobe writes task or config
            if (config_space) begin
              config_write <= 1'b1;
            end else begin
              task_write <= 1'b1;
            end
          end
          `MODE_IO: begin
            // RULE7: I/O strobe writes config only
            config_write <= config_space;
          end
          `MODE_IDE: begin
            // RULE8: strobe ignored in IDE
            config_write <= 1'b0;
          end
          default: begin
            task_write <= 1'b0;
          end
        endcase
      end
    end
  end

  // Flow-control and status pins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_ready <= `WAIT_IDLE;
      udma_write_ready_n <= 1'b1;
      udma_read_strobe <= `STROBE_RESET;
      write_protect_pin <= `WP_RESET;
      port_is_wide_n <= 1'b1;
      port_is_wide_oe <= 1'b1;
      word_cycle_select_n <= 1'b1;
      voltage_sense_primary_n <= 1'b0;
      voltage_sense_primary_oe <= 1'b0;
      voltage_sense_secondary_oe <= 1'b1;
    end else if (ce) begin
      // RULE12: primary sense always driven low
      voltage_sense_primary_n <= 1'b0;
      voltage_sense_primary_oe <= 1'b0;
      // RULE12: secondary never driven
      voltage_sense_secondary_oe <= 1'b1;
      // RULE14: idle high when no cycle
      if (pins_s[1]) begin
        wait_ready <= `WAIT_IDLE;
      end else if (mode == `MODE_IDE && udma_write_active) begin
        // Pin belongs to write-ready during Ultra DMA write
        wait_ready <= `WAIT_IDLE;
      end else begin
        // RULE1: low holds cycle; RULE2: same pin is ready in IDE
        wait_ready <= ~core_busy;
      end
      // RULE3: negate to pause write
      udma_write_ready_n <= ~(mode == `MODE_IDE && udma_write_active && udma_can_accept);
      // RULE5: no new edges pause output
      udma_read_strobe <= (mode == `MODE_IDE) ? strobe_raw : `STROBE_RESET;
      // RULE9: low after initialization
      write_protect_pin <= ~init_done;
      case (mode)
        `MODE_IO: begin
          // RULE10: wide port flagged low
          port_is_wide_n <= ~port_wide;
          port_is_wide_oe <= 1'b0;
          word_cycle_select_n <= 1'b1;
        end
        `MODE_IDE: begin
          // RULE11: low on expected word cycle
          word_cycle_select_n <= ~word_expected;
          port_is_wide_n <= ~word_expected;
          port_is_wide_oe <= 1'b0;
        end
        default: begin
          // Memory mode: pin carries write-protect instead
          port_is_wide_n <= ~init_done;
          port_is_wide_oe <= 1'b0;
          word_cycle_select_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // card_host_flow

// *** card_host_flow_sva.sv ***
// Checker for the card flow-control pins, bound to card_host_flow.
// Assumes one clock domain and the one-cycle status latency of the note.
`timescale 1ns/10ps
module card_host_flow_sva (
  input wire clk, resetn, ce, host_cycle_n, core_busy, word_expected,
  input wire udma_write_active, udma_can_accept, udma_read_active, udma_word_send,
  input wire wait_ready, udma_write_ready_n, udma_read_strobe, write_protect_pin,
  input wire word_cycle_select_n, voltage_sense_primary_n, voltage_sense_primary_oe,
  input wire voltage_sense_secondary_oe, task_write, config_write, init_done,
  input wire [2:0] mode
);
  // All checks share the core clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Five cycles cover the two-stage pin synchroniser and the output register with margin
  a_idle_wait_high: assert property (host_cycle_n[*5] |-> wait_ready)
    else $error("wait asserted with no host cycle");
  a_busy_holds_wait: assert property ((ce && !host_cycle_n && core_busy)[*5] |-> !wait_ready)
    else $error("busy card did not hold the host");
  a_write_ready_pause: assert property ($past(ce && udma_write_active && !udma_can_accept)
    |-> udma_write_ready_n) else $error("write ready not negated");
  // Word request reaches the pin two edges later: generator, then output register
  a_strobe_word_edge: assert property (($past(ce && udma_read_active && udma_word_send, 2)
    && mode == 3'h4 && $past(mode) == 3'h4) |-> $changed(udma_read_strobe))
    else $error("no strobe edge for word");
  a_strobe_pause_hold: assert property ((!$past(udma_word_send, 2)
    && $past(udma_read_active, 2) && $past(mode) == mode) |-> $stable(udma_read_strobe))
    else $error("strobe moved without a word");
  a_wp_after_init: assert property ($past(init_done) |-> !write_protect_pin)
    else $error("write protect high after init");
  a_ide_no_write: assert property (mode == 3'h4 |-> !(task_write || config_write))
    else $error("write pulse in IDE mode");
  a_write_pulse_once: assert property ((task_write || config_write) |-> init_done
    ##1 !(task_write || config_write)) else $error("bad write pulse");
  a_word_cycle_sel: assert property ((mode == 3'h4 && $past(mode) == 3'h4 && $past(ce))
    |-> word_cycle_select_n == !$past(word_expected)) else $error("word select wrong");
  a_sense_pins: assert property (!voltage_sense_primary_n && !voltage_sense_primary_oe
    && voltage_sense_secondary_oe) else $error("sense pins wrong");
  c_config_write: cover property (config_write);
  c_task_write: cover property (task_write);
  c_strobe_edge: cover property ($changed(udma_read_strobe));
endmodule // card_host_flow_sva

bind card_host_flow card_host_flow_sva chk (.*);

// *** host_model.sv ***
// Host adapter model: one host cycle per go pulse; write strobe only when ide is low.
// Assumes go is raised at a rising edge only while done is high.
`timescale 1ns/10ps
module host_model (
  input wire clk, go, ide, wait_ready,
  output logic host_cycle_n, write_strobe_n, done
);
  // Pins released high between cycles, as with pull-ups
  initial begin
    host_cycle_n = 1'b1;
    write_strobe_n = 1'b1;
    done = 1'b1;
    forever begin
      @(negedge clk);
      if (go) begin
        done = 1'b0;
        host_cycle_n = 1'b0;
        write_strobe_n = ide;
        repeat (4) @(negedge clk);
        while (!wait_ready) @(negedge clk);
        write_strobe_n = 1'b1;
        host_cycle_n = 1'b1;
        repeat (3) @(negedge clk);
        done = 1'b1;
      end
    end
  end
endmodule // host_model

// *** pin_sync.v ***
// Two-flip-flop synchroniser for a bus of host pins.
// Assumes pins are asynchronous to clk; first stage is read only by the second.
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  // First stage, read only by the second
  reg [WIDTH-1:0] meta;

  // Both stages freeze while the clock enable is low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync

// *** tb.sv ***
// Self-checking bench for card_host_flow with a host model.
// Assumes inputs move at the falling edge and INIT_COUNT is shortened to 2.
`timescale 1ns/10ps
module tb;
  logic clk = 0, resetn = 0, ce = 1, interface_select_n = 1, config_space = 0, core_busy = 0;
  logic port_wide = 0, word_expected = 0, udma_write_active = 0, udma_can_accept = 0;
  logic udma_read_active = 0, udma_word_send = 0, go = 0;
  logic last_stb = 0;
  wire host_cycle_n, write_strobe_n, done, wait_ready, udma_write_ready_n, udma_read_strobe;
  wire write_protect_pin, port_is_wide_n, port_is_wide_oe, word_cycle_select_n, init_done;
  wire voltage_sense_primary_n, voltage_sense_primary_oe, voltage_sense_secondary_oe;
  wire task_write, config_write;
  wire [2:0] mode;
  int err_total = 0, n_tests = 0, n_tw = 0, n_cw = 0, n_edge = 0;
  logic [31:0] seed = 32'h1151c;

  card_host_flow #(.INIT_COUNT(2)) DUT (.*);
  host_model HOST (.clk(clk), .go(go), .ide(!interface_select_n), .wait_ready(wait_ready),
    .host_cycle_n(host_cycle_n), .write_strobe_n(write_strobe_n), .done(done));

  // Fixed-seed xorshift keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected pulse of one kind for a write
  function automatic int exp_hit(input logic kind, ide);
    return (kind && !ide) ? 1 : 0;
  endfunction
  task chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up();
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Count pulses and strobe edges seen at each rising edge
  always @(posedge clk) begin
    n_tw += (task_write === 1'b1);
    n_cw += (config_write === 1'b1);
    n_edge += (udma_read_strobe !== last_stb);
    last_stb = udma_read_strobe;
  end
  // Random host writes, some stalled by a busy card
  task run_writes(input logic ide);
    int et, ec;
    et = n_tw;
    ec = n_cw;
    repeat (12) begin
      @(negedge clk) {config_space, core_busy, port_wide} = 3'(rnd());
      ec += exp_hit(config_space, ide);
      et += exp_hit(!config_space, ide);
      @(posedge clk) go = 1;
      @(posedge clk) go = 0;
      repeat (8) @(negedge clk);
      core_busy = 0;
      for (int i = 0; i < 60 && !done; i++) @(posedge clk);
    end
    chk(8'(n_cw), 8'(ec));
    chk(8'(n_tw), 8'(et));
  endtask
  task do_reset(input logic sel);
    @(negedge clk) resetn = 0;
    interface_select_n = sel;
    repeat (20) @(negedge clk);
    resetn = 1;
    repeat (10) @(negedge clk);
  endtask

  initial forever #2.5 clk = ~clk;
  initial begin
    #30000;
    err_total++;
    wrap_up();
  end
  initial begin
    int e, e0;
    do_reset(1);
    chk(write_protect_pin, 0);
    chk({voltage_sense_primary_n, voltage_sense_primary_oe, voltage_sense_secondary_oe}, 1);
    chk(mode, 8'h1);
    run_writes(0);
    do_reset(0);
    chk(mode, 8'h4);
    run_writes(1);
    // Random word requests in IDE mode; idle cycles must leave the strobe still
    @(negedge clk) udma_read_active = 1;
    repeat (4) @(negedge clk);
    e0 = n_edge;
    e = 0;
    repeat (40) begin
      @(negedge clk) udma_word_send = 1'(rnd());
      e += udma_word_send;
    end
    @(negedge clk) udma_word_send = 0;
    repeat (4) @(negedge clk);
    chk(8'(n_edge - e0), 8'(e));
    udma_write_active = 1;
    repeat (16) begin
      @(negedge clk) {word_expected, udma_can_accept} = 2'(rnd());
      @(negedge clk);
      chk(word_cycle_select_n, !word_expected);
      chk(udma_write_ready_n, !udma_can_accept);
      chk(port_is_wide_n, !word_expected);
      chk(wait_ready, 1);
    end
    wrap_up();
  end
endmodule // tb

// *** udma_strobe_gen.v ***
// Ultra DMA data-out strobe generator: toggles once per data word.
// Assumes a one-cycle word request from same-clock logic.
`include "card_flow_map.vh"
`timescale 1ns/10ps
module udma_strobe_gen (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire burst_active,
  input wire word_send,
  output reg strobe
);
  // Each word produces one edge, rising or falling, so the host latches on both;
  // no word, no edge, which is how a burst pauses
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe <= `STROBE_RESET;
    end else if (ce) begin
      if (!burst_active) begin
        // Park low between bursts
        strobe <= `STROBE_RESET;
      end else if (word_send) begin
        strobe <= ~strobe;
      end
    end
  end
endmodule // udma_strobe_gen
